/* include/herr_pkg.sv */
// constants for the host bridge error reporting and retry timer block
`default_nettype none
package herr_pkg;
  localparam logic [7:0] ADDR_CMD = 8'hc0;
  localparam logic [7:0] ADDR_STS = 8'hc4;
  localparam logic [7:0] ADDR_RTMR = 8'hc8;
  localparam logic [31:0] CMD_RESET = 32'h00000010;
  localparam logic [31:0] CMD_MASK = 32'h00003fdd;
  localparam logic [31:0] STS_MASK = 32'h001f0a0d;
  localparam logic [31:0] RTMR_RESET = 32'h00000003;
  localparam logic [31:0] RTMR_MASK = 32'hffff001f;
  localparam int CMD_HARDFAIL = 13;
  localparam int CMD_MABORT = 12;
  localparam int CMD_UNCORR = 11;
  localparam int CMD_CORR = 10;
  localparam int CMD_TOREP = 9;
  localparam int CMD_WDOG = 8;
  localparam int CMD_AE2SERR = 7;
  localparam int CMD_BE2SERR = 6;
  localparam int CMD_BE2INIT = 4;
  localparam int CMD_PV2INIT = 3;
  localparam int CMD_BUS_ERROR_SIGNAL = 2;
  localparam int CMD_ADDRESS_ERROR_SIGNAL = 0;
  localparam int STS_HFAIL = 20;
  localparam int STS_APAR = 19;
  localparam int STS_RPAR = 18;
  localparam int STS_CORR = 17;
  localparam int STS_PROT = 16;
  localparam int STS_UNCORR = 11;
  localparam int STS_TMO = 9;
  localparam int STS_INIT = 3;
  localparam int STS_BUS_ERROR_SIGNAL = 2;
  localparam int STS_ADDRESS_ERROR_SIGNAL = 0;
  localparam int RT_HOST_LSB = 16;
  localparam int RT_PCI_LSB = 2;
  localparam int RT_CNT_EN = 1;
  localparam int RT_PARK_EN = 0;
  localparam int CLK_MHZ = 20;
  localparam int WDOG_SHORT_US = 1500;
  localparam int WDOG_LONG_US = 30000;
  localparam int WDOG_SHORT_CYC = WDOG_SHORT_US * CLK_MHZ;
  localparam int WDOG_LONG_CYC = WDOG_LONG_US * CLK_MHZ;
  localparam logic [2:0] PCI_CODE_MAX = 3'h4;
  localparam logic [7:0] PCI_BASE_CNT = 8'h08;
endpackage : herr_pkg
`default_nettype wire

/* core/herr_retry_cnt.sv */
// reloadable down counter giving a one-cycle expiry pulse
`default_nettype none
module herr_retry_cnt #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic tick,
  input wire logic [WIDTH-1:0] load,
  output logic expired
);
  logic [WIDTH-1:0] cnt_ff;
  logic run_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        cnt_ff <= load;
        run_ff <= (load != '0);
      end
      else if (run_ff && tick)
      begin
        if (cnt_ff == WIDTH'(1))
        begin
          run_ff <= 1'b0;
          expired <= 1'b1;
        end
        cnt_ff <= cnt_ff - WIDTH'(1);
      end
    end
  end
endmodule : herr_retry_cnt
`default_nettype wire

/* core/herr_regs.sv */
// error reporting command/status and retry timer register bank
`default_nettype none
module herr_regs #(
  parameter int WDOG_SHORT = herr_pkg::WDOG_SHORT_CYC,
  parameter int WDOG_LONG = herr_pkg::WDOG_LONG_CYC,
  parameter bit AUX_BRIDGE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic hostResetN,
  input wire logic [1:0] addrStrap,
  input wire logic pciSerrEn,
  input wire logic wdogLongSel,
  input wire logic pciClkTick,
  input wire logic hostReqError,
  input wire logic hostReqPerr,
  input wire logic pciMasterAbort,
  input wire logic hostRespPhase,
  input wire logic ioqNotEmpty,
  input wire logic unclaimedTxn,
  input wire logic eccSingle,
  input wire logic eccMulti,
  input wire logic addrParErr,
  input wire logic reqParErr,
  input wire logic protViol,
  input wire logic hardFailRsp,
  input wire logic hardFailPosted,
  input wire logic secondAerr,
  input wire logic busErrorSeen,
  input wire logic busInitSeen,
  input wire logic addrErrSeen,
  input wire logic busErrCond,
  input wire logic outRdRetried,
  input wire logic retriedAgentBack,
  input wire logic inRetried,
  input wire logic pciParkSeen,
  output logic hardFailOut,
  output logic serrOut,
  output logic readAllOnes,
  output logic pciMabortSts,
  output logic eccCorrectEn,
  output logic wdogClaim,
  output logic busErrorOut,
  output logic busInitOut,
  output logic addrErrorOut,
  output logic inPostReenable,
  output logic outPostReenable
);
  import herr_pkg::*;

  logic [31:0] cmdFf;
  logic [31:0] stsFf;
  logic [31:0] rtmrFf;
  logic hostResetHiFf;
  logic aerrInEnFf;
  logic berrInEnFf;
  logic [2:0] hostResetSync;
  logic [2:0] busErrSync;
  logic [2:0] addrErrSync;
  logic [31:0] wdogCntFf;
  logic timeoutEv;
  logic [31:0] nxt_sts;
  logic [31:0] setVec;
  logic [7:0] pciLoad;
  logic hostExp;
  logic pciExp;
  logic reportEv;

  // three-flop synchronisers for pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hostResetSync <= 3'h0;
      busErrSync <= 3'h0;
      addrErrSync <= 3'h0;
    end
    else
    begin
      hostResetSync <= {hostResetSync[1:0], hostResetN};
      busErrSync <= {busErrSync[1:0], busErrorSeen};
      addrErrSync <= {addrErrSync[1:0], addrErrSeen};
    end
  end

  // strap capture at reset rising edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aerrInEnFf <= 1'b0;
      berrInEnFf <= 1'b0;
      hostResetHiFf <= 1'b0;
    end
    else if (hostResetSync[2] == hostResetSync[1])
    begin
      // filtered level follows once the last two stages agree
      hostResetHiFf <= hostResetSync[2];
      if (hostResetSync[2] && !hostResetHiFf)
      begin
        aerrInEnFf <= addrStrap[0];
        berrInEnFf <= addrStrap[1];
      end
    end
  end

  // command and retry timer registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmdFf <= CMD_RESET;
      rtmrFf <= RTMR_RESET;
    end
    else if (regWr)
    begin
      if (regAddr == ADDR_CMD)
        cmdFf <= regWdata & CMD_MASK;
      if (regAddr == ADDR_RTMR)
        rtmrFf <= regWdata & RTMR_MASK;
    end
  end

  // host bus watchdog
  always_ff @(posedge clk)
  begin
    if (rst || !cmdFf[CMD_WDOG] || AUX_BRIDGE || hostRespPhase || !ioqNotEmpty)
      wdogCntFf <= 32'h0;
    else
      wdogCntFf <= wdogCntFf + 32'h1;
  end
  assign timeoutEv = (wdogCntFf == 32'(wdogLongSel ? WDOG_LONG : WDOG_SHORT)) && !AUX_BRIDGE;

  assign reportEv = (hostReqError && !hostReqPerr) || (pciMasterAbort && cmdFf[CMD_MABORT])
    || (timeoutEv && cmdFf[CMD_TOREP]);

  always_comb
  begin
    setVec = 32'h0;
    setVec[STS_HFAIL] = (hardFailRsp && !hardFailPosted) || secondAerr;
    setVec[STS_APAR] = addrParErr;
    setVec[STS_RPAR] = reqParErr;
    setVec[STS_CORR] = eccSingle;
    setVec[STS_PROT] = protViol;
    setVec[STS_UNCORR] = eccMulti;
    setVec[STS_TMO] = timeoutEv;
    setVec[STS_INIT] = busInitSeen;
    setVec[STS_BUS_ERROR_SIGNAL] = busErrSync[2] & busErrSync[1];
    setVec[STS_ADDRESS_ERROR_SIGNAL] = addrErrSync[2] & addrErrSync[1];
    nxt_sts = stsFf;
    if (regWr && regAddr == ADDR_STS)
      nxt_sts = stsFf & ~regWdata;
    nxt_sts = (nxt_sts | setVec) & STS_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      stsFf <= 32'h0;
    else
      stsFf <= nxt_sts;
  end

  // read mux
  always_ff @(posedge clk)
  begin
    if (rst)
      regRdata <= 32'h0;
    else if (regRd)
    begin
      unique case (regAddr)
        ADDR_CMD: regRdata <= cmdFf;
        ADDR_STS: regRdata <= stsFf;
        ADDR_RTMR: regRdata <= rtmrFf;
        default: regRdata <= 32'h0;
      endcase
    end
  end

  // error signalling outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hardFailOut <= 1'b0;
      serrOut <= 1'b0;
      readAllOnes <= 1'b0;
      pciMabortSts <= 1'b0;
      eccCorrectEn <= 1'b0;
      wdogClaim <= 1'b0;
      busErrorOut <= 1'b0;
      busInitOut <= 1'b0;
      addrErrorOut <= 1'b0;
    end
    else
    begin
      hardFailOut <= reportEv && cmdFf[CMD_HARDFAIL];
      serrOut <= (reportEv && !cmdFf[CMD_HARDFAIL])
        || (cmdFf[CMD_AE2SERR] && aerrInEnFf && pciSerrEn && addrErrSync[2] && addrErrSync[1])
        || (cmdFf[CMD_BE2SERR] && berrInEnFf && busErrSync[2] && busErrSync[1]);
      readAllOnes <= (pciMasterAbort && cmdFf[CMD_MABORT]) || (timeoutEv && cmdFf[CMD_TOREP]);
      pciMabortSts <= pciMasterAbort;
      eccCorrectEn <= cmdFf[CMD_CORR];
      wdogClaim <= timeoutEv && cmdFf[CMD_WDOG] && unclaimedTxn;
      busErrorOut <= cmdFf[CMD_BUS_ERROR_SIGNAL] && (busErrCond || (eccMulti && cmdFf[CMD_UNCORR]));
      busInitOut <= (cmdFf[CMD_BE2INIT] && busErrSync[2] && busErrSync[1])
        || (cmdFf[CMD_PV2INIT] && protViol);
      addrErrorOut <= cmdFf[CMD_ADDRESS_ERROR_SIGNAL] && reqParErr;
    end
  end

  // retry counters
  always_comb
  begin
    pciLoad = 8'h0;
    if (rtmrFf[RT_PCI_LSB +: 3] != 3'h0 && rtmrFf[RT_PCI_LSB +: 3] <= PCI_CODE_MAX)
      pciLoad = PCI_BASE_CNT << rtmrFf[RT_PCI_LSB +: 3];
  end

  herr_retry_cnt #(.WIDTH(16)) u_host_cnt (
    .clk(clk),
    .rst(rst || retriedAgentBack),
    .start(outRdRetried),
    .tick(1'b1),
    .load(rtmrFf[RT_HOST_LSB +: 16]),
    .expired(hostExp)
  );

  herr_retry_cnt #(.WIDTH(8)) u_pci_cnt (
    .clk(clk),
    .rst(rst),
    .start(inRetried),
    .tick(pciClkTick),
    .load(pciLoad),
    .expired(pciExp)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inPostReenable <= 1'b0;
      outPostReenable <= 1'b0;
    end
    else
    begin
      inPostReenable <= hostExp;
      outPostReenable <= (rtmrFf[RT_CNT_EN] && pciExp) || (rtmrFf[RT_PARK_EN] && pciParkSeen);
    end
  end

  AST_STS_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (regWr && regAddr == ADDR_STS && regWdata[STS_PROT] && !protViol) |=> !stsFf[STS_PROT])
    else $error("status flag not cleared");
  AST_STS_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    protViol |=> stsFf[STS_PROT])
    else $error("protocol flag lost");
  AST_HF_SERR: assert property (@(posedge clk) disable iff (rst)
    (reportEv && cmdFf[CMD_HARDFAIL]) |=> hardFailOut)
    else $error("hard fail missing");
  AST_MABORT: assert property (@(posedge clk) disable iff (rst)
    pciMasterAbort |=> pciMabortSts)
    else $error("master abort status missing");
  AST_CORR: assert property (@(posedge clk) disable iff (rst)
    eccSingle |=> stsFf[STS_CORR])
    else $error("corrected flag missing");
  AST_ADDR_ERR: assert property (@(posedge clk) disable iff (rst)
    (reqParErr && cmdFf[CMD_ADDRESS_ERROR_SIGNAL]) |=> addrErrorOut)
    else $error("address error not driven");
  AST_RSVD: assert property (@(posedge clk) disable iff (rst)
    (cmdFf & ~CMD_MASK) == 32'h0 && (rtmrFf & ~RTMR_MASK) == 32'h0)
    else $error("reserved bit set");
  AST_PARK: assert property (@(posedge clk) disable iff (rst)
    (pciParkSeen && rtmrFf[RT_PARK_EN]) |=> outPostReenable)
    else $error("parking re-enable missing");
  COV_TMO: cover property (@(posedge clk) timeoutEv);
  COV_HOSTEXP: cover property (@(posedge clk) hostExp);
  COV_PCIEXP: cover property (@(posedge clk) pciExp);
endmodule : herr_regs
`default_nettype wire

/* sim/herr_far_model.sv */
// far side model: pci clock enables and host bus error pins
`default_nettype none
module herr_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic berrReq,
  input wire logic aerrReq,
  output logic pciClkTick,
  output logic busErrorSeen,
  output logic addrErrSeen
);
  // arbiter retry mask code, fixed at 1 and not tied to the programmed one
  localparam logic [2:0] MASK_CODE = 3'h1;
  // pci clock at half the host rate
  always_ff @(negedge clk)
    pciClkTick <= rst ? 1'b0 : ~pciClkTick;
  always_comb busErrorSeen = berrReq;
  always_comb addrErrSeen = aerrReq;
endmodule : herr_far_model
`default_nettype wire

/* sim/herr_regs_tb.sv */
// self-checking testbench for the error reporting block
`default_nettype none
module herr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import herr_pkg::*;
  logic clk = 0, rst = 1, regWr = 0, regRd = 0, hostResetN = 0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [1:0] addrStrap = 2'h3;
  logic pciSerrEn = 1, wdogLongSel = 0, pciClkTick, hostReqError = 0, hostReqPerr = 0;
  logic pciMasterAbort = 0, hostRespPhase = 0, ioqNotEmpty = 0, unclaimedTxn = 0;
  logic eccSingle = 0, eccMulti = 0, addrParErr = 0, reqParErr = 0, protViol = 0;
  logic hardFailRsp = 0, hardFailPosted = 0, secondAerr = 0, busErrorSeen, busInitSeen = 0;
  logic addrErrSeen, busErrCond = 0, outRdRetried = 0, retriedAgentBack = 0, inRetried = 0;
  logic pciParkSeen = 0, berrReq = 0, aerrReq = 0;
  logic hardFailOut, serrOut, readAllOnes, pciMabortSts, eccCorrectEn, wdogClaim;
  logic busErrorOut, busInitOut, addrErrorOut, inPostReenable, outPostReenable;
  int fails = 0, n_compared = 0;
  logic [31:0] d;
  always #25 clk = ~clk;
  herr_far_model far (.clk, .rst, .berrReq, .aerrReq, .pciClkTick, .busErrorSeen, .addrErrSeen);
  herr_regs #(.WDOG_SHORT(20), .WDOG_LONG(40)) uut (.clk, .rst, .regAddr, .regWr, .regRd,
    .regWdata, .regRdata, .hostResetN, .addrStrap, .pciSerrEn, .wdogLongSel, .pciClkTick,
    .hostReqError, .hostReqPerr, .pciMasterAbort, .hostRespPhase, .ioqNotEmpty, .unclaimedTxn,
    .eccSingle, .eccMulti, .addrParErr, .reqParErr, .protViol, .hardFailRsp, .hardFailPosted,
    .secondAerr, .busErrorSeen, .busInitSeen, .addrErrSeen, .busErrCond, .outRdRetried,
    .retriedAgentBack, .inRetried, .pciParkSeen, .hardFailOut, .serrOut, .readAllOnes,
    .pciMabortSts, .eccCorrectEn, .wdogClaim, .busErrorOut, .busInitOut, .addrErrorOut,
    .inPostReenable, .outPostReenable);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    regAddr = a;
    regWdata = v;
    regWr = 1;
    @(negedge clk);
    regWr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRd = 1;
    @(negedge clk);
    regRd = 0;
    d = regRdata;
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse
  task automatic t_reset_map;
    rd(ADDR_CMD); chk(d, 32'h00000010);
    rd(ADDR_STS); chk(d, 32'h0);
    rd(ADDR_RTMR); chk(d, 32'h00000003);
    rd(8'hcc); chk(d, 32'h0);
    wr(ADDR_CMD, 32'hffffffff); rd(ADDR_CMD); chk(d, 32'h00003fdd);
    chk(eccCorrectEn, 1);
    wr(ADDR_RTMR, 32'hffffffff); rd(ADDR_RTMR); chk(d, 32'hffff001f);
    wr(ADDR_STS, 32'hffffffff); rd(ADDR_STS); chk(d, 32'h0);
    $display("test reset_map done");
  endtask : t_reset_map
  task automatic t_status;
    hardFailPosted = 1;
    pulse(hardFailRsp);
    hardFailPosted = 0;
    rd(ADDR_STS);
    chk(d, 32'h0);
    pulse(hardFailRsp); pulse(addrParErr); pulse(reqParErr); pulse(eccSingle);
    pulse(protViol); pulse(eccMulti); pulse(busInitSeen);
    rd(ADDR_STS); chk(d, 32'h001f0808);
    wr(ADDR_STS, 32'h0); rd(ADDR_STS); chk(d, 32'h001f0808);
    wr(ADDR_STS, 32'h00100000); rd(ADDR_STS); chk(d, 32'h000f0808);
    pulse(secondAerr); rd(ADDR_STS); chk(d, 32'h001f0808);
    wr(ADDR_STS, 32'hffffffff); rd(ADDR_STS); chk(d, 32'h0);
    // clear and new event in the same cycle: the event wins
    @(negedge clk);
    regAddr = ADDR_STS;
    regWdata = 32'h00010000;
    regWr = 1;
    protViol = 1;
    @(negedge clk);
    regWr = 0;
    protViol = 0;
    rd(ADDR_STS);
    chk(d, 32'h00010000);
    $display("test status done");
  endtask : t_status
  task automatic t_report;
    int n, e;
    wr(ADDR_CMD, 32'h00002000);
    pulse(hostReqError); chk({hardFailOut, serrOut}, 2'h2);
    hostReqPerr = 1;
    pulse(hostReqError);
    hostReqPerr = 0;
    chk(hardFailOut, 0);
    wr(ADDR_CMD, 32'h00001000);
    pulse(pciMasterAbort); chk({readAllOnes, serrOut, pciMabortSts}, 3'h7);
    wr(ADDR_CMD, 32'h0);
    pulse(pciMasterAbort); chk({readAllOnes, pciMabortSts}, 2'h1);
    pulse(hostReqError); chk({hardFailOut, serrOut}, 2'h1);
    pulse(busErrCond); chk(busErrorOut, 0);
    wr(ADDR_CMD, 32'h00000004);
    pulse(busErrCond); chk(busErrorOut, 1);
    pulse(reqParErr); chk(addrErrorOut, 0);
    wr(ADDR_CMD, 32'h00000005);
    pulse(reqParErr);
    chk(addrErrorOut, 1);
    pulse(eccMulti);
    chk(busErrorOut, 0);
    wr(ADDR_CMD, 32'h00000804);
    pulse(eccMulti);
    chk(busErrorOut, 1);
    wr(ADDR_CMD, 32'h00000300);
    for (int sel = 0; sel < 2; sel++)
    begin
      e = (sel == 1) ? 40 : 20;
      wdogLongSel = sel[0];
      ioqNotEmpty = 1;
      unclaimedTxn = 1;
      for (n = 0; n < 100 && wdogClaim !== 1; n++) @(negedge clk);
      chk(wdogClaim, 1);
      chk(n >= e && n <= e + 2, 1);
      chk(readAllOnes, 1);
      ioqNotEmpty = 0;
      unclaimedTxn = 0;
      rd(ADDR_STS);
      chk(d[STS_TMO], 1);
      wr(ADDR_STS, 32'h00000200);
    end
    wdogLongSel = 0;
    $display("test report done");
  endtask : t_report
  task automatic t_bus_error_signal;
    int n;
    wr(ADDR_STS, 32'hffffffff); wr(ADDR_CMD, 32'h00000010);
    @(negedge clk); berrReq = 1;
    for (n = 0; n < 10 && busInitOut !== 1; n++) @(negedge clk);
    chk(busInitOut, 1);
    berrReq = 0; rd(ADDR_STS); chk(d[STS_BUS_ERROR_SIGNAL], 1);
    wr(ADDR_CMD, 32'h00000040);
    berrReq = 1;
    for (n = 0; n < 10 && serrOut !== 1; n++) @(negedge clk);
    chk(serrOut, 1);
    berrReq = 0;
    wr(ADDR_CMD, 32'h00000080);
    repeat (4) @(negedge clk);
    aerrReq = 1;
    for (n = 0; n < 10 && serrOut !== 1; n++) @(negedge clk);
    chk(serrOut, 1);
    aerrReq = 0;
    pciSerrEn = 0;
    repeat (6) @(negedge clk);
    aerrReq = 1;
    repeat (6) @(negedge clk);
    chk(serrOut, 0);
    aerrReq = 0;
    pciSerrEn = 1;
    rd(ADDR_STS);
    chk(d[STS_ADDRESS_ERROR_SIGNAL], 1);
    $display("test bus_error_signal done");
  endtask : t_bus_error_signal
  task automatic t_retry;
    int c, e;
    for (int code = 1; code <= 4; code++)
    begin
      wr(ADDR_RTMR, {27'h0, 3'(code), 2'h2});
      pulse(inRetried);
      e = 2 * (8 << code);
      for (c = 1; c < 300 && outPostReenable !== 1; c++) @(negedge clk);
      chk(c >= e - 3 && c <= e + 4, 1);
    end
    wr(ADDR_RTMR, 32'h00000002); pulse(inRetried);
    for (c = 0; c < 60 && outPostReenable !== 1; c++) @(negedge clk);
    chk(outPostReenable, 0);
    wr(ADDR_RTMR, 32'h00000001);
    pulse(pciParkSeen); chk(outPostReenable, 1);
    wr(ADDR_RTMR, 32'h000a0000);
    pulse(outRdRetried);
    for (c = 1; c < 40 && inPostReenable !== 1; c++) @(negedge clk);
    chk(c >= 10 && c <= 13, 1);
    pulse(outRdRetried);
    pulse(retriedAgentBack);
    for (c = 0; c < 30 && inPostReenable !== 1; c++) @(negedge clk);
    chk(inPostReenable, 0);
    wr(ADDR_RTMR, 32'h00000000);
    pulse(outRdRetried);
    for (c = 0; c < 30 && inPostReenable !== 1; c++) @(negedge clk);
    chk(inPostReenable, 0);
    $display("test retry done");
  endtask : t_retry
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 0;
    hostResetN = 1;
    repeat (6) @(negedge clk);
    t_reset_map();
    t_status();
    t_report();
    t_bus_error_signal();
    t_retry();
    tally_and_finish();
  end
endmodule : herr_regs_tb
`default_nettype wire
